// ---- design/usb_err_map.svh ----
// Register offsets, field positions, reset values and timing counts of the
// USB error and status block. Assumes inclusion by bare name.
`ifndef USB_ERR_MAP_SVH
`define USB_ERR_MAP_SVH

// Word indices on the Avalon-MM slave (byte address = 4 * index)
`define USB_ERR_STATUS_IDX     3'h0
`define USB_ERR_ENABLE_IDX     3'h1
`define USB_XFER_STATUS_IDX    3'h2
`define USB_CONTROL_IDX        3'h3
`define USB_IRQ_ENABLE_IDX     3'h4
`define USB_IRQ_FLAG_IDX       3'h5

// Error status / enable bit positions
`define USB_ERR_PID_BIT        0
`define USB_ERR_CRC5_EOF_BIT   1
`define USB_ERR_CRC16_BIT      2
`define USB_ERR_PARTIAL_BIT    3
`define USB_ERR_TURNAROUND_BIT 4
`define USB_ERR_DMA_BIT        5
`define USB_ERR_BUSMATRIX_BIT  6
`define USB_ERR_STUFF_BIT      7

// Interrupt enable / flag bit positions
`define USB_IRQ_UERR_BIT       1
`define USB_IRQ_TRN_BIT        3

// Control register bit positions
`define USB_CON_EN_SOF_BIT     0
`define USB_CON_PINGPONG_POINTER_RESET_BIT     1
`define USB_CON_RESUME_BIT     2
`define USB_CON_HOST_BIT       3
`define USB_CON_BUSRST_BIT     4
`define USB_CON_HALT_BIT       5
`define USB_CON_SE0_BIT        6
`define USB_CON_LIVE_J_LEVEL_BIT     7

// Reset values
`define USB_REG8_RESET         8'h00

// Timing
`define USB_CLK_PERIOD_NS      50
`define USB_SOF_PERIOD_NS      1000000
`define USB_SOF_PERIOD_CYCLES  (`USB_SOF_PERIOD_NS / `USB_CLK_PERIOD_NS)
`define USB_TURNAROUND_BITS    5'h10

// Status queue
`define USB_STAT_DEPTH         4
`define USB_STAT_WIDTH         6

`endif

// ---- design/usb_err_pkg.sv ----
// Types shared by the USB error and status block.
// Assumes usb_err_map.svh for the constants themselves.
package usb_err_pkg;

  // One completed-transaction entry of the status queue
  typedef struct packed {
    logic [3:0] ep;
    logic       tx;
    logic       odd;
  } stat_entry_type;

  // Turnaround watch state
  typedef enum logic [0:0] {
    TA_IDLE,
    TA_WAIT
  } ta_state_type;

endpackage : usb_err_pkg

// ---- design/usb_stat_fifo.sv ----
// Four-entry queue of six-bit completed-transaction status entries.
// Assumes one clock, asynchronous active-low reset, pop only when not empty.
`timescale 1ns/1ps
`default_nettype none
`include "usb_err_map.svh"

module usb_stat_fifo (
  input  wire logic                       ref_clk_in,
  input  wire logic                       rstn_in,
  input  wire logic                       push_in,
  input  wire logic [`USB_STAT_WIDTH-1:0] push_data_in,
  input  wire logic                       pop_in,
  output logic      [`USB_STAT_WIDTH-1:0] head_out,
  output logic                            visible_out,
  output logic                            full_out
);

  logic [`USB_STAT_WIDTH-1:0] mem_q [`USB_STAT_DEPTH];
  logic [1:0]                 wr_ptr_q;
  logic [1:0]                 rd_ptr_q;
  logic [2:0]                 count_q;
  logic                       do_push;
  logic                       do_pop;

  // A push into a full queue is dropped; the oldest entries are kept
  assign full_out = (count_q == 3'(`USB_STAT_DEPTH));
  assign do_push  = push_in & ~full_out;
  assign do_pop   = pop_in & (count_q != 3'h0);

  // Storage
  always_ff @(posedge ref_clk_in) begin
    if (do_push) begin
      mem_q[wr_ptr_q] <= push_data_in;
    end
  end

  // Pointers and occupancy
  always_ff @(posedge ref_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      wr_ptr_q <= 2'h0;
      rd_ptr_q <= 2'h0;
      count_q  <= 3'h0;
    end else begin
      if (do_push) begin
        wr_ptr_q <= wr_ptr_q + 2'h1;
      end
      if (do_pop) begin
        rd_ptr_q <= rd_ptr_q + 2'h1;
      end
      count_q <= count_q + {2'h0, do_push} - {2'h0, do_pop};
    end
  end

  // Head and its valid mark are registered together so they always agree
  always_ff @(posedge ref_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      head_out    <= '0;
      visible_out <= 1'b0;
    end else begin
      head_out    <= (count_q != 3'h0) ? mem_q[rd_ptr_q] : '0;
      visible_out <= (count_q != 3'h0);
    end
  end

endmodule : usb_stat_fifo
`default_nettype wire

// ---- design/usb_err_status.sv ----
// USB error flags, error enables, transfer status queue and control register.
// Assumes the serial engine drives one-cycle event pulses on ref_clk_in and
// software reaches the registers over Avalon-MM with waitrequest.
//
// Register access over Avalon-MM and the address map are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
`include "usb_err_map.svh"

module usb_err_status #(
  parameter int unsigned SOF_PERIOD_CYCLES = `USB_SOF_PERIOD_CYCLES
) (
  input  wire logic        ref_clk_in,
  input  wire logic        rstn_in,
  // Avalon-MM slave
  input  wire logic [2:0]  avs_address_in,
  input  wire logic        avs_read_in,
  input  wire logic        avs_write_in,
  input  wire logic [31:0] avs_writedata_in,
  input  wire logic [3:0]  avs_byteenable_in,
  output logic      [31:0] avs_readdata_out,
  output logic             avs_waitrequest_out,
  // Event pulses from the serial engine
  input  wire logic        pid_check_fail_in,
  input  wire logic        token_crc_fail_in,
  input  wire logic        data_crc_fail_in,
  input  wire logic        partial_byte_in,
  input  wire logic        stuffing_error_in,
  input  wire logic        bus_matrix_error_in,
  input  wire logic        dma_grant_late_in,
  input  wire logic        rx_truncated_in,
  input  wire logic        xfer_active_in,
  input  wire logic        bit_time_tick_in,
  input  wire logic        eop_expect_reply_in,
  input  wire logic        reply_start_in,
  input  wire logic        setup_token_in,
  input  wire logic        token_in_progress_in,
  input  wire logic        transaction_done_in,
  input  wire logic [3:0]  last_ep_number_in,
  input  wire logic        last_is_tx_in,
  input  wire logic        last_bank_is_odd_in,
  // Live bus levels from the transceiver
  input  wire logic        live_j_level_in,
  input  wire logic        live_se0_level_in,
  // Control outputs
  output logic             module_enable_out,
  output logic             pingpong_pointer_reset_out,
  output logic             resume_signal_out,
  output logic             host_role_enable_out,
  output logic             bus_reset_generate_out,
  output logic             packet_processing_halt_out,
  output logic             host_logic_reset_out,
  output logic             sof_token_send_out,
  output logic             combined_usb_irq_out
);

  localparam int unsigned SOF_CNT_W = $clog2(SOF_PERIOD_CYCLES);

  // Bus access decode
  logic        ack_q;
  logic        req;
  logic        wr_take;
  logic        rd_first;
  logic        wr_lane0;
  logic [7:0]  wbyte;

  // Register state
  logic [7:0]  err_flags_q;
  logic [7:0]  err_set;
  logic [7:0]  err_enable_q;
  logic [7:0]  irq_enable_q;
  logic        halt_q;
  logic        busrst_q;
  logic        host_q;
  logic        host_prev_q;
  logic        resume_q;
  logic        pingpong_pointer_reset_q;
  logic        en_sof_q;
  logic [7:0]  control_view;
  logic [7:0]  xfer_view;
  logic [7:0]  irq_flag_view;

  // Status queue
  usb_err_pkg::stat_entry_type stat_head;
  usb_err_pkg::stat_entry_type stat_push;
  logic        token_complete_flag;
  logic        stat_pop;

  // Host timing and turnaround
  logic [SOF_CNT_W-1:0]         sof_cnt_q;
  logic                         sof_zero;
  logic                         host_toggle;
  usb_err_pkg::ta_state_type    ta_state_q;
  logic [4:0]                   ta_bits_q;
  logic                         ta_timeout;

  // Live level synchronisers
  logic [1:0]  live_s1_q;
  logic [1:0]  live_s2_q;
  logic [1:0]  live_s3_q;
  logic [1:0]  live_q;

  logic        summary_error;

  // Every access takes one wait cycle; read data is captured in that cycle
  assign req                 = avs_read_in | avs_write_in;
  assign avs_waitrequest_out = req & ~ack_q;
  assign wr_take             = avs_write_in & ack_q;
  assign rd_first            = avs_read_in & ~ack_q;
  assign wr_lane0            = wr_take & avs_byteenable_in[0];
  assign wbyte               = avs_writedata_in[7:0];

  // Access phase tracker
  always_ff @(posedge ref_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= req & ~ack_q;
    end
  end

  // Three-stage capture of the asynchronous line levels
  always_ff @(posedge ref_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      live_s1_q <= 2'h0;
      live_s2_q <= 2'h0;
      live_s3_q <= 2'h0;
      live_q    <= 2'h0;
    end else begin
      live_s1_q <= {live_j_level_in, live_se0_level_in};
      live_s2_q <= live_s1_q;
      live_s3_q <= live_s2_q;
      // A change is believed only once two later stages agree
      if (live_s2_q == live_s3_q) begin
        live_q <= live_s3_q;
      end
    end
  end

  // Start-of-frame timer: reloads on its own zero and on a role change
  assign host_toggle = (host_q != host_prev_q);
  assign sof_zero    = (sof_cnt_q == '0);

  always_ff @(posedge ref_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      host_prev_q <= 1'b0;
      sof_cnt_q   <= SOF_CNT_W'(SOF_PERIOD_CYCLES - 1);
    end else begin
      host_prev_q <= host_q;
      if (host_toggle || !host_q || !en_sof_q || sof_zero) begin
        sof_cnt_q <= SOF_CNT_W'(SOF_PERIOD_CYCLES - 1);
      end else begin
        sof_cnt_q <= sof_cnt_q - 1'b1;
      end
    end
  end

  // One SOF every period in host mode while SOF sending is on
  assign sof_token_send_out   = host_q & en_sof_q & sof_zero & ~host_toggle;
  assign host_logic_reset_out = host_toggle;

  // Turnaround watch: counts idle bit-times after an end-of-packet
  always_ff @(posedge ref_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      ta_state_q <= usb_err_pkg::TA_IDLE;
      ta_bits_q  <= 5'h00;
    end else begin
      unique case (ta_state_q)
        usb_err_pkg::TA_IDLE: begin
          ta_bits_q <= 5'h00;
          if (eop_expect_reply_in && !host_toggle) begin
            ta_state_q <= usb_err_pkg::TA_WAIT;
          end
        end
        usb_err_pkg::TA_WAIT: begin
          if (reply_start_in || ta_timeout || host_toggle) begin
            ta_state_q <= usb_err_pkg::TA_IDLE;
          end else if (bit_time_tick_in) begin
            ta_bits_q <= ta_bits_q + 5'h01;
          end
        end
      endcase
    end
  end

  // The seventeenth idle bit-time with no reply is the time-out
  assign ta_timeout = (ta_state_q == usb_err_pkg::TA_WAIT) & bit_time_tick_in &
                      ~reply_start_in & (ta_bits_q == `USB_TURNAROUND_BITS);

  // Hardware set terms for each error flag
  always_comb begin
    err_set = 8'h00;
    err_set[`USB_ERR_PID_BIT]        = pid_check_fail_in;
    err_set[`USB_ERR_CRC5_EOF_BIT]   = host_q ? (sof_zero & en_sof_q & xfer_active_in)
                                              : token_crc_fail_in;
    err_set[`USB_ERR_CRC16_BIT]      = data_crc_fail_in;
    err_set[`USB_ERR_PARTIAL_BIT]    = partial_byte_in;
    err_set[`USB_ERR_TURNAROUND_BIT] = ta_timeout;
    err_set[`USB_ERR_DMA_BIT]        = dma_grant_late_in | rx_truncated_in;
    err_set[`USB_ERR_BUSMATRIX_BIT]  = bus_matrix_error_in;
    err_set[`USB_ERR_STUFF_BIT]      = stuffing_error_in;
  end

  // Sticky flags, write-one-to-clear; a same-cycle event beats the clear
  always_ff @(posedge ref_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      err_flags_q <= `USB_REG8_RESET;
    end else if (wr_lane0 && avs_address_in == `USB_ERR_STATUS_IDX) begin
      err_flags_q <= (err_flags_q & ~wbyte) | err_set;
    end else begin
      err_flags_q <= err_flags_q | err_set;
    end
  end

  // Error enables
  always_ff @(posedge ref_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      err_enable_q <= `USB_REG8_RESET;
    end else if (wr_lane0 && avs_address_in == `USB_ERR_ENABLE_IDX) begin
      err_enable_q <= wbyte;
    end
  end

  // Main interrupt enables: summary error and token complete
  always_ff @(posedge ref_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      irq_enable_q <= `USB_REG8_RESET;
    end else if (wr_lane0 && avs_address_in == `USB_IRQ_ENABLE_IDX) begin
      irq_enable_q <= wbyte & 8'h0a;
    end
  end

  // Control register; the halt bit is also set by hardware on SETUP in device mode
  always_ff @(posedge ref_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      halt_q   <= 1'b0;
      busrst_q <= 1'b0;
      host_q   <= 1'b0;
      resume_q <= 1'b0;
      pingpong_pointer_reset_q <= 1'b0;
      en_sof_q <= 1'b0;
    end else begin
      if (wr_lane0 && avs_address_in == `USB_CONTROL_IDX) begin
        busrst_q <= wbyte[`USB_CON_BUSRST_BIT];
        host_q   <= wbyte[`USB_CON_HOST_BIT];
        resume_q <= wbyte[`USB_CON_RESUME_BIT];
        pingpong_pointer_reset_q <= wbyte[`USB_CON_PINGPONG_POINTER_RESET_BIT];
        en_sof_q <= wbyte[`USB_CON_EN_SOF_BIT];
        halt_q   <= wbyte[`USB_CON_HALT_BIT] | (setup_token_in & ~host_q);
      end else if (setup_token_in && !host_q) begin
        halt_q <= 1'b1;
      end
    end
  end

  assign module_enable_out          = en_sof_q & ~host_q;
  assign pingpong_pointer_reset_out = pingpong_pointer_reset_q;
  assign resume_signal_out          = resume_q;
  assign host_role_enable_out       = host_q;
  assign bus_reset_generate_out     = busrst_q;
  assign packet_processing_halt_out = halt_q & ~host_q;

  // Completed transactions enter the queue; clearing token-complete pops it
  assign stat_push = '{ep: last_ep_number_in, tx: last_is_tx_in, odd: last_bank_is_odd_in};
  assign stat_pop  = wr_lane0 && (avs_address_in == `USB_IRQ_FLAG_IDX) &&
                     wbyte[`USB_IRQ_TRN_BIT] && token_complete_flag;

  usb_stat_fifo u_stat_fifo (
    .ref_clk_in   (ref_clk_in),
    .rstn_in      (rstn_in),
    .push_in      (transaction_done_in),
    .push_data_in (stat_push),
    .pop_in       (stat_pop),
    .head_out     (stat_head),
    .visible_out  (token_complete_flag),
    .full_out     ()
  );

  // Transfer status view: zero whenever no entry is valid
  assign xfer_view = token_complete_flag ?
                     {stat_head.ep, stat_head.tx, stat_head.odd, 2'b00} : 8'h00;

  // Error summary: each flag gated by its own enable
  assign summary_error = |(err_flags_q & err_enable_q);

  // Combined request; errors need the summary enable as well
  assign combined_usb_irq_out = (summary_error & irq_enable_q[`USB_IRQ_UERR_BIT]) |
                                (token_complete_flag & irq_enable_q[`USB_IRQ_TRN_BIT]);

  // Control view: bit 5 shows token busy in host mode, halt in device mode
  always_comb begin
    control_view = 8'h00;
    control_view[`USB_CON_LIVE_J_LEVEL_BIT] = live_q[1];
    control_view[`USB_CON_SE0_BIT]    = live_q[0];
    control_view[`USB_CON_HALT_BIT]   = host_q ? token_in_progress_in : halt_q;
    control_view[`USB_CON_BUSRST_BIT] = busrst_q;
    control_view[`USB_CON_HOST_BIT]   = host_q;
    control_view[`USB_CON_RESUME_BIT] = resume_q;
    control_view[`USB_CON_PINGPONG_POINTER_RESET_BIT] = pingpong_pointer_reset_q;
    control_view[`USB_CON_EN_SOF_BIT] = en_sof_q;
  end

  // Interrupt flag view: summary error is read-only, token complete is W1C
  always_comb begin
    irq_flag_view = 8'h00;
    irq_flag_view[`USB_IRQ_UERR_BIT] = summary_error;
    irq_flag_view[`USB_IRQ_TRN_BIT]  = token_complete_flag;
  end

  // Read data captured in the wait cycle; unmapped words read zero
  always_ff @(posedge ref_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      avs_readdata_out <= 32'h0;
    end else if (rd_first) begin
      unique case (avs_address_in)
        `USB_ERR_STATUS_IDX:  avs_readdata_out <= {24'h0, err_flags_q};
        `USB_ERR_ENABLE_IDX:  avs_readdata_out <= {24'h0, err_enable_q};
        `USB_XFER_STATUS_IDX: avs_readdata_out <= {24'h0, xfer_view};
        `USB_CONTROL_IDX:     avs_readdata_out <= {24'h0, control_view};
        `USB_IRQ_ENABLE_IDX:  avs_readdata_out <= {24'h0, irq_enable_q};
        `USB_IRQ_FLAG_IDX:    avs_readdata_out <= {24'h0, irq_flag_view};
        default:              avs_readdata_out <= 32'h0;
      endcase
    end
  end

endmodule : usb_err_status
`default_nettype wire

// ---- tb/usb_err_status_assertions.sv ----
// Port checker for the USB error and status block.
// Assumes a bind onto usb_err_status; one clock, async active-low reset.
`timescale 1ns/1ps
`default_nettype none
module usb_err_status_checker #(
  parameter int unsigned SOF_PERIOD_CYCLES = 50
) (
  input wire logic        ref_clk_in,
  input wire logic        rstn_in,
  input wire logic [2:0]  avs_address_in,
  input wire logic        avs_read_in,
  input wire logic        avs_write_in,
  input wire logic [31:0] avs_writedata_in,
  input wire logic [31:0] avs_readdata_out,
  input wire logic        avs_waitrequest_out,
  input wire logic        setup_token_in,
  input wire logic        host_role_enable_out,
  input wire logic        packet_processing_halt_out,
  input wire logic        host_logic_reset_out,
  input wire logic        sof_token_send_out,
  input wire logic        combined_usb_irq_out
);
  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (!rstn_in);
  logic        done_wr;
  logic        uerr_en_q;
  logic        trn_en_q;
  logic [15:0] gap_q;
  logic        gap_ok_q;
  // Completing edge of a write
  assign done_wr = avs_write_in && !avs_waitrequest_out;
  // Shadow of the interrupt enables, judged from bus traffic alone
  always_ff @(posedge ref_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      uerr_en_q <= 1'b0;
      trn_en_q  <= 1'b0;
    end else if (done_wr && avs_address_in == 3'h4) begin
      uerr_en_q <= avs_writedata_in[1];
      trn_en_q  <= avs_writedata_in[3];
    end
  end
  // Cycles since last frame start; a host toggle voids the count
  always_ff @(posedge ref_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      gap_q    <= 16'h0;
      gap_ok_q <= 1'b0;
    end else if (sof_token_send_out) begin
      gap_q    <= 16'h0;
      gap_ok_q <= 1'b1;
    end else begin
      gap_q <= gap_q + 16'h1;
      if (host_logic_reset_out) gap_ok_q <= 1'b0;
    end
  end
  a_rdata_upper_zero: assert property (
    avs_read_in && !avs_waitrequest_out |-> avs_readdata_out[31:8] == 24'h0)
    else $error("upper read data bits not zero");
  a_wait_one_cycle: assert property (
    (avs_read_in || avs_write_in) && avs_waitrequest_out |=> !avs_waitrequest_out)
    else $error("more than one wait cycle");
  a_wait_idle_low: assert property (
    !(avs_read_in || avs_write_in) |-> !avs_waitrequest_out)
    else $error("waitrequest high while idle");
  a_irq_needs_summary: assert property (
    combined_usb_irq_out && !trn_en_q |-> uerr_en_q)
    else $error("error irq without summary enable");
  a_sof_host_only: assert property (
    sof_token_send_out |-> host_role_enable_out)
    else $error("frame start outside host mode");
  a_sof_period_exact: assert property (
    sof_token_send_out && gap_ok_q |-> gap_q == 16'(SOF_PERIOD_CYCLES - 1))
    else $error("frame start spacing wrong");
  a_host_toggle_reset: assert property (
    $changed(host_role_enable_out) |-> host_logic_reset_out)
    else $error("host toggle without logic reset");
  a_host_reset_single: assert property (
    host_logic_reset_out |=> !host_logic_reset_out)
    else $error("host reset too long");
  a_setup_sets_halt: assert property (
    setup_token_in && !host_role_enable_out |=> packet_processing_halt_out)
    else $error("setup did not halt");
  a_halt_holds: assert property (
    packet_processing_halt_out && !(done_wr && avs_address_in == 3'h3)
      |=> packet_processing_halt_out)
    else $error("halt dropped early");
  c_sof_seen: cover property (sof_token_send_out);
  c_host_reset: cover property (host_logic_reset_out);
  c_halt_set: cover property (packet_processing_halt_out);
  c_irq_up: cover property (combined_usb_irq_out);
endmodule : usb_err_status_checker

bind usb_err_status usb_err_status_checker #(.SOF_PERIOD_CYCLES(SOF_PERIOD_CYCLES)) u_chk (.*);
`default_nettype wire

// ---- tb/usb_far_side_model.sv ----
// Stand-in for the serial engine: error pulses, status pushes, bit ticks.
// Assumes tasks are called between rising edges.
`timescale 1ns/1ps
`default_nettype none
module usb_far_side_model (
  input  wire logic       ref_clk_in,
  output logic      [7:0] ev_out,
  output logic            tick_out,
  output logic            eop_out,
  output logic            reply_out,
  output logic            done_out,
  output logic      [5:0] stat_out,
  output logic            j_out
);
  logic [1:0] div_q = 2'h0;
  // Idle bus rests in J; everything else quiet
  initial begin
    {ev_out, stat_out, eop_out, reply_out, done_out} = 17'h0;
    j_out = 1'b1;
  end
  // Bit time every four clocks, free-running as on a live bus
  always @(posedge ref_clk_in) begin
    div_q <= div_q + 2'h1;
    tick_out <= (div_q == 2'h3);
  end
  task fire(input int k);
    @(posedge ref_clk_in);
    ev_out[k] <= 1'b1;
    @(posedge ref_clk_in);
    ev_out[k] <= 1'b0;
  endtask : fire
  // End of packet aligned off a tick, then n ticks, then an optional reply
  task ta_watch(input int n, input bit reply);
    int c;
    c = 0;
    do @(posedge ref_clk_in); while (tick_out !== 1'b1);
    eop_out <= 1'b1;
    @(posedge ref_clk_in);
    eop_out <= 1'b0;
    while (c < n) begin
      @(posedge ref_clk_in);
      if (tick_out === 1'b1) c++;
    end
    if (reply) begin
      reply_out <= 1'b1;
      @(posedge ref_clk_in);
      reply_out <= 1'b0;
    end
  endtask : ta_watch
  task push(input logic [5:0] s);
    @(posedge ref_clk_in);
    stat_out <= s;
    done_out <= 1'b1;
    @(posedge ref_clk_in);
    done_out <= 1'b0;
  endtask : push
endmodule : usb_far_side_model
`default_nettype wire

// ---- tb/usb_error_and_status_reporting_bench.sv ----
// Self-checking bench for usb_err_status over its Avalon-MM slave.
// Assumes usb_far_side_model plays the serial engine; short frame period.
`timescale 1ns/1ps
`default_nettype none
module usb_error_and_status_reporting_bench;
  localparam int SOF_P = 50;
  logic ref_clk_in, rstn_in, avs_read_in, avs_write_in, avs_waitrequest_out;
  logic [2:0] avs_address_in;
  logic [3:0] avs_byteenable_in;
  logic [31:0] avs_writedata_in, avs_readdata_out;
  logic [7:0] ev;
  logic [5:0] stat;
  logic xfer, tick, eop, reply, setup, done, jlev;
  logic module_enable_out, host_role_enable_out, packet_processing_halt_out;
  logic host_logic_reset_out, sof_token_send_out, combined_usb_irq_out;
  int error_cnt, comparisons, cyc, hrst_n, t0, t1;
  logic [7:0] st [5] = '{8'hf8, 8'h04, 8'hac, 8'h50, 8'h3c};
  usb_err_status #(.SOF_PERIOD_CYCLES(SOF_P)) u_dut (
    .ref_clk_in, .rstn_in, .avs_address_in, .avs_read_in, .avs_write_in,
    .avs_writedata_in, .avs_byteenable_in, .avs_readdata_out, .avs_waitrequest_out,
    .pid_check_fail_in(ev[0]), .token_crc_fail_in(ev[1]), .data_crc_fail_in(ev[2]),
    .partial_byte_in(ev[3]), .rx_truncated_in(ev[4]), .dma_grant_late_in(ev[5]),
    .bus_matrix_error_in(ev[6]), .stuffing_error_in(ev[7]), .xfer_active_in(xfer),
    .bit_time_tick_in(tick), .eop_expect_reply_in(eop), .reply_start_in(reply),
    .setup_token_in(setup), .token_in_progress_in(xfer), .transaction_done_in(done),
    .last_ep_number_in(stat[5:2]), .last_is_tx_in(stat[1]), .last_bank_is_odd_in(stat[0]),
    .live_j_level_in(jlev), .live_se0_level_in(1'b0), .module_enable_out,
    .pingpong_pointer_reset_out(), .resume_signal_out(), .host_role_enable_out,
    .bus_reset_generate_out(), .packet_processing_halt_out, .host_logic_reset_out,
    .sof_token_send_out, .combined_usb_irq_out
  );
  usb_far_side_model u_far (
    .ref_clk_in, .ev_out(ev), .tick_out(tick), .eop_out(eop),
    .reply_out(reply), .done_out(done), .stat_out(stat), .j_out(jlev)
  );
  // 20 MHz clock
  initial begin
    ref_clk_in = 1'b0;
    forever #25 ref_clk_in = ~ref_clk_in;
  end
  // Cycle stamp and host reset pulse count
  always @(posedge ref_clk_in) begin
    cyc <= cyc + 1;
    if (host_logic_reset_out === 1'b1) hrst_n <= hrst_n + 1;
  end
  task give_verdict();
    $display("comparisons %0d mismatches %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : give_verdict
  task check(input string nm, input logic [31:0] e, input logic [31:0] g);
    comparisons++;
    if (g !== e) begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask : check
  // One access; request held until waitrequest is sampled low at a rising edge
  task bus(input logic rd, input logic [2:0] a, input logic [31:0] d, input logic [3:0] be,
           output logic [31:0] q);
    int n;
    n = 0;
    @(posedge ref_clk_in);
    avs_address_in <= a;
    avs_writedata_in <= d;
    avs_byteenable_in <= be;
    avs_read_in <= rd;
    avs_write_in <= !rd;
    do begin
      @(posedge ref_clk_in);
      n++;
    end while (avs_waitrequest_out !== 1'b0 && n < 50);
    q = avs_readdata_out;
    avs_read_in <= 1'b0;
    avs_write_in <= 1'b0;
    if (n >= 50) begin
      check("waitrequest", 32'h0, 32'h1);
      give_verdict();
    end
  endtask : bus
  task wr(input logic [2:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b0, a, d, 4'hf, q);
  endtask : wr
  task rc(input string nm, input logic [2:0] a, input logic [31:0] e);
    logic [31:0] q;
    bus(1'b1, a, 32'h0, 4'hf, q);
    check(nm, e, q);
  endtask : rc
  task irq_chk(input logic e);
    @(negedge ref_clk_in);
    check("usb irq", {31'h0, e}, {31'h0, combined_usb_irq_out});
  endtask : irq_chk
  task wait_sof(output int t);
    int n;
    n = 0;
    do begin
      @(negedge ref_clk_in);
      n++;
    end while (sof_token_send_out !== 1'b1 && n < 200);
    if (n >= 200) begin
      check("frame start", 32'h1, 32'h0);
      give_verdict();
    end
    t = cyc;
  endtask : wait_sof
  // Main sequence
  initial begin
    logic [31:0] e;
    {rstn_in, avs_read_in, avs_write_in, xfer, setup, avs_address_in, avs_writedata_in} = 40'h0;
    {cyc, hrst_n, error_cnt, comparisons} = '0;
    avs_byteenable_in = 4'hf;
    repeat (2) @(posedge ref_clk_in);
    rstn_in <= 1'b1;
    for (int i = 0; i < 8; i++) rc("reset value", 3'(i), (i == 3) ? 32'h80 : 32'h0);
    $display("test reset values done");
    wr(3'h1, 32'hffffffff);
    rc("error enable", 3'h1, 32'hff);
    bus(1'b0, 3'h1, 32'h55, 4'h0, e);
    rc("masked write", 3'h1, 32'hff);
    wr(3'h1, 32'h0);
    $display("test enable register done");
    // Index 8 is a turnaround time-out, index 4 a truncated packet
    for (int k = 0; k < 9; k++) begin
      e = 32'h01 << ((k == 8) ? 4 : (k == 4) ? 5 : k);
      if (k == 8) u_far.ta_watch(17, 1'b0);
      else u_far.fire(k);
      rc("error flag", 3'h0, e);
      wr(3'h0, 32'h0);
      rc("flag after zero", 3'h0, e);
      wr(3'h0, e);
      rc("flag after one", 3'h0, 32'h0);
    end
    u_far.ta_watch(16, 1'b1);
    repeat (80) @(posedge ref_clk_in);
    rc("answered turnaround", 3'h0, 32'h0);
    $display("test error flags done");
    u_far.fire(0);
    wr(3'h1, 32'h01);
    irq_chk(1'b0);
    wr(3'h4, 32'h02);
    irq_chk(1'b1);
    rc("irq flag", 3'h5, 32'h02);
    wr(3'h1, 32'h02);
    irq_chk(1'b0);
    u_far.fire(1);
    irq_chk(1'b1);
    wr(3'h1, 32'h0);
    wr(3'h0, 32'h03);
    $display("test interrupt gating done");
    for (int i = 0; i < 5; i++) u_far.push(st[i][7:2]);
    repeat (2) @(posedge ref_clk_in);
    for (int i = 0; i < 4; i++) begin
      rc("token complete", 3'h5, 32'h08);
      rc("transfer status", 3'h2, {24'h0, st[i]});
      wr(3'h5, 32'h08);
      repeat (2) @(posedge ref_clk_in);
    end
    rc("queue drained", 3'h5, 32'h0);
    rc("status when clear", 3'h2, 32'h0);
    $display("test status queue done");
    @(posedge ref_clk_in) setup <= 1'b1;
    @(posedge ref_clk_in) setup <= 1'b0;
    rc("halt set", 3'h3, 32'ha0);
    wr(3'h3, 32'h01);
    @(negedge ref_clk_in);
    check("halt out", 32'h1, {31'h0, module_enable_out & ~packet_processing_halt_out});
    $display("test processing halt done");
    @(posedge ref_clk_in) xfer <= 1'b1;
    wr(3'h3, 32'h09);
    repeat (2) @(posedge ref_clk_in);
    check("host reset count", 32'h1, 32'(hrst_n));
    wait_sof(t0);
    wait_sof(t1);
    check("frame period", 32'(SOF_P), 32'(t1 - t0));
    @(posedge ref_clk_in) xfer <= 1'b0;
    rc("frame end error", 3'h0, 32'h02);
    wr(3'h0, 32'h02);
    wr(3'h3, 32'h0);
    repeat (2) @(posedge ref_clk_in);
    check("host reset count", 32'h2, 32'(hrst_n));
    $display("test host frames done");
    give_verdict();
  end
endmodule : usb_error_and_status_reporting_bench
`default_nettype wire
